// >>> src/scl_pkg.sv
package scl_pkg;
    // Bus map, byte addresses
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_PC = 8'h04;
    localparam logic [7:0] OFS_OPA = 8'h08;
    localparam logic [7:0] OFS_OPB = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_USP = 8'h14;
    localparam logic [7:0] OFS_ISP = 8'h18;
    localparam logic [7:0] OFS_FLG = 8'h1c;
    localparam logic [7:0] OFS_INTERRUPT_TABLE_BASE = 8'h20;
    localparam logic [2:0] GPR_PAGE = 3'h2;
    // Command word and status register fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_FORM_BIT = 3;
    localparam int CMD_MEM_BIT = 4;
    localparam int CMD_DST_LSB = 5;
    localparam int CMD_LEN_LSB = 8;
    localparam int STAT_BUSY = 0;
    localparam int STAT_ERR = 1;
    localparam int STAT_IBLK = 2;
    // Flag bits
    localparam int FLG_Z_BIT = 2;
    localparam int FLG_S_BIT = 3;
    localparam int FLG_U_BIT = 7;
    typedef enum logic [2:0] {
        OP_DCALL = 3'h0, OP_ICALL = 3'h1, OP_SCALL = 3'h2, OP_CLOAD = 3'h3,
        OP_CTX = 3'h4, OP_ELOAD = 3'h5, OP_ITBL = 3'h6, OP_NONE = 3'h7
    } scl_op_e;
    typedef enum logic [2:0] {
        DST_FB = 3'h0, DST_SB = 3'h1, DST_SP = 3'h2, DST_ISP = 3'h3,
        DST_FLG = 3'h4, DST_ITBH = 3'h5, DST_ITBL = 3'h6, DST_BAD = 3'h7
    } scl_dst_e;
    // General registers: R0..R3, address_reg_zero/one, static_base, frame_base
    localparam logic [2:0] GPR_A0 = 3'h4;
    localparam logic [2:0] GPR_A1 = 3'h5;
    localparam logic [2:0] GPR_SB = 3'h6;
    localparam logic [2:0] GPR_FB = 3'h7;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_READ = 3'b001, ST_PUSH = 3'b011,
        ST_EXEC = 3'b010, ST_ITBL = 3'b110, ST_POP = 3'b111
    } scl_st_e;
    localparam logic signed [19:0] DCALL_MIN = -20'sh07fff;
    localparam logic signed [19:0] DCALL_MAX = 20'sh08000;
    localparam logic [19:0] VEC_TOP = 20'hffffe;
    localparam logic [19:0] VEC_LO = 20'hffe00;
    localparam logic [7:0] PAGE_MIN = 8'h12;
    localparam logic [3:0] PCH_SPECIAL = 4'hf;
    localparam logic [3:0] SCALL_LEN = 4'h2;
    localparam logic [15:0] PUSH_OFS_H = 16'h0001;
    localparam logic [15:0] PUSH_OFS_L = 16'h0003;
    localparam logic [15:0] PUSH_OFS_M = 16'h0002;
    localparam logic [15:0] POP_STEP = 16'h0002;
    // Index of the last byte of a read burst
    localparam logic [1:0] RD_B = 2'h0;
    localparam logic [1:0] RD_W = 2'h1;
    localparam logic [1:0] RD_A = 2'h2;
    typedef struct packed {
        logic valid;
        logic we;
        logic [19:0] addr;
        logic [7:0] wdata;
    } scl_mem_s;
endpackage : scl_pkg

// >>> src/scl_exec.sv
`timescale 1ns/1ps
// Overview of operation
// - Direct call: word offset -32767..+32768 from start, or absolute 20-bit target.
// - Calls: SP-1, store high return byte; SP-2, store middle and low bytes.
// - Indirect word call adds sign-extended operand to start; address form loads it.
// - Memory operand read low byte first: 2 bytes word form, 3 address form.
// - Operand address holds low byte; higher bytes follow at rising addresses.
// - Special-page call: upper PC bits 0F, low 16 from FFFFE minus twice page.
// - Vector table spans FFE00..FFFDA; page 255 lowest entry, page 18 highest.
// - Control load copies register, memory or immediate into chosen control register.
// - No interrupt accepted at boundary right after a control-register load.
// - Stack pointer load writes the pointer chosen by the stack-select flag.
// - Control load changes flags only when the destination is the flag register.
// - Context restore reads task number at 16-bit address, table base 20-bit.
// - Selection byte at base plus twice task; correction byte at next address.
// - Restore pops only selected registers, then adds correction to stack pointer.
// - Extended load uses 20-bit source; byte into address register zero-extends.
// - Extended load: sign flag is bit 15 (bit 7 for byte into data register), zero flag over that same width.
// - Table base load writes 20-bit immediate as high half then low half.
module scl_exec
    import scl_pkg::*;
(
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_SRST,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // Byte memory port
    output scl_mem_s O_MEM,
    input wire logic I_MEM_READY,
    input wire logic [7:0] I_MEM_RDATA,
    // Core status
    output logic O_BUSY,
    output logic O_IRQ_BLOCK,
    output logic [19:0] O_PC
);

    function automatic logic [19:0] stk_addr(input logic [15:0] a);
        return {4'h0, a};
    endfunction : stk_addr

    scl_st_e st_reg;
    scl_st_e st_next;
    scl_st_e go_st;
    scl_st_e rd_st;
    scl_op_e op_reg;
    scl_op_e w_op;
    scl_dst_e w_dst;
    logic form_reg, mem_reg, ctx_ph_reg, half_reg;
    logic [2:0] dst_reg, idx_reg;
    logic [3:0] len_reg;
    logic [1:0] cnt_reg, last_reg, go_last;
    logic [19:0] rd_addr_reg, go_addr;
    logic [23:0] buf_reg;
    logic [7:0] sel_reg, corr_reg;
    logic [15:0] off_reg;
    logic [19:0] pc_reg, opa_reg, interrupt_table_base_reg;
    logic [15:0] opb_reg, usp_reg, isp_reg, flg_reg;
    logic [15:0] gpr_reg [8];
    logic err_reg, iblk_reg;

    // Bus decode
    wire apb_acc = I_PSEL & I_PENABLE;
    wire idle = (st_reg == ST_IDLE);
    wire apb_wr = apb_acc & I_PWRITE & idle;
    wire hit_gpr = (I_PADDR[7:5] == GPR_PAGE) && (I_PADDR[1:0] == 2'h0);
    wire mapped = hit_gpr || (I_PADDR inside {OFS_CMD, OFS_PC, OFS_OPA, OFS_OPB,
        OFS_STAT, OFS_USP, OFS_ISP, OFS_FLG, OFS_INTERRUPT_TABLE_BASE});
    wire cmd_wr = apb_wr & (I_PADDR == OFS_CMD);

    // Command decode
    assign w_op = scl_op_e'(I_PWDATA[CMD_OP_LSB +: 3]);
    assign w_dst = scl_dst_e'(I_PWDATA[CMD_DST_LSB +: 3]);
    wire w_form = I_PWDATA[CMD_FORM_BIT];
    wire w_mem = I_PWDATA[CMD_MEM_BIT];
    wire disp_ok = ($signed(opa_reg) >= DCALL_MIN) && ($signed(opa_reg) <= DCALL_MAX);
    wire page_ok = opa_reg[7:0] >= PAGE_MIN;
    wire go_err = cmd_wr & ((w_op == OP_NONE) | ((w_op == OP_DCALL) & !w_form & !disp_ok)
        | ((w_op == OP_SCALL) & !page_ok) | ((w_op == OP_CLOAD) & (w_dst == DST_BAD)));
    wire go = cmd_wr & !go_err;
    assign go_addr = (w_op == OP_SCALL) ? VEC_TOP - {11'h0, opa_reg[7:0], 1'b0}
        : (w_op == OP_CTX) ? stk_addr(opb_reg)
        : opa_reg;
    assign go_last = (w_op == OP_ICALL) ? (w_form ? RD_A : RD_W)
        : (w_op == OP_ELOAD) ? (w_form ? RD_W : RD_B)
        : (w_op == OP_CTX) ? RD_B : RD_W;
    assign go_st = (w_op == OP_DCALL) ? ST_PUSH
        : (w_op == OP_ICALL) ? (w_mem ? ST_READ : ST_PUSH)
        : (w_op == OP_CLOAD) ? (w_mem ? ST_READ : ST_EXEC)
        : (w_op == OP_ITBL) ? ST_EXEC : ST_READ;

    // Memory sequencing
    wire sp_sel_u = flg_reg[FLG_U_BIT];
    wire [15:0] sp_cur = sp_sel_u ? usp_reg : isp_reg;
    wire mem_take = O_MEM.valid & I_MEM_READY;
    wire rd_done = (st_reg == ST_READ) & mem_take & (cnt_reg == last_reg);
    wire push_done = (st_reg == ST_PUSH) & mem_take & (cnt_reg == RD_A);
    wire pop_sel = sel_reg[idx_reg];
    wire pop_step = (st_reg == ST_POP) & (!pop_sel | (mem_take & half_reg));
    wire pop_done = pop_step & (idx_reg == 3'h7);
    wire is_call = (op_reg == OP_DCALL) | (op_reg == OP_ICALL) | (op_reg == OP_SCALL);
    assign rd_st = is_call ? ST_PUSH : (op_reg == OP_CTX) ? (ctx_ph_reg ? ST_POP : ST_READ)
        : ST_EXEC;

    // Call targets and return address
    wire [3:0] ret_len = (op_reg == OP_SCALL) ? SCALL_LEN : len_reg;
    wire [19:0] ret_addr = pc_reg + {16'h0, ret_len};
    wire [19:0] call_tgt = (op_reg == OP_DCALL) ? (form_reg ? opa_reg : pc_reg + opa_reg)
        : (op_reg == OP_ICALL) ? (form_reg ? buf_reg[19:0]
            : pc_reg + {{4{buf_reg[15]}}, buf_reg[15:0]})
        : {PCH_SPECIAL, buf_reg[15:0]};
    wire [15:0] push_ofs = (cnt_reg == RD_B) ? PUSH_OFS_H
        : (cnt_reg == RD_W) ? PUSH_OFS_L : PUSH_OFS_M;
    wire [7:0] push_byte = (cnt_reg == RD_B) ? {4'h0, ret_addr[19:16]}
        : (cnt_reg == RD_W) ? ret_addr[7:0] : ret_addr[15:8];

    assign O_MEM.valid = (st_reg == ST_READ) | (st_reg == ST_PUSH) | ((st_reg == ST_POP) & pop_sel);
    assign O_MEM.we = (st_reg == ST_PUSH);
    assign O_MEM.addr = (st_reg == ST_PUSH) ? stk_addr(sp_cur - push_ofs)
        : (st_reg == ST_POP) ? stk_addr(sp_cur + off_reg + {15'h0, half_reg})
        : rd_addr_reg;
    assign O_MEM.wdata = push_byte;

    // Extended load result
    wire el_wide = form_reg | (dst_reg == GPR_A0) | (dst_reg == GPR_A1);
    wire [15:0] el_val = form_reg ? buf_reg[15:0]
        : el_wide ? {8'h0, buf_reg[7:0]}
        : {gpr_reg[dst_reg][15:8], buf_reg[7:0]};
    wire el_msb = el_wide ? el_val[15] : el_val[7];
    wire el_zero = el_wide ? (el_val == 16'h0) : (el_val[7:0] == 8'h0);
    wire exec_cl = (st_reg == ST_EXEC) & (op_reg == OP_CLOAD);
    wire exec_el = (st_reg == ST_EXEC) & (op_reg == OP_ELOAD);

    // Stack pointer updates from calls, context restore and SP control load
    wire sp_we = push_done | pop_done | (exec_cl & (dst_reg == DST_SP));
    wire [15:0] sp_wv = push_done ? sp_cur - PUSH_OFS_L
        : pop_done ? sp_cur + {8'h0, corr_reg} : buf_reg[15:0];

    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            ST_IDLE: if (go) st_next = go_st;
            ST_READ: if (rd_done) st_next = rd_st;
            ST_PUSH: if (push_done) st_next = ST_IDLE;
            ST_EXEC: st_next = (op_reg == OP_ITBL) ? ST_ITBL : ST_IDLE;
            ST_ITBL: st_next = ST_IDLE;
            ST_POP: if (pop_done) st_next = ST_IDLE;
            default: st_next = ST_IDLE;
        endcase
    end

    // Sequencer state
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            st_reg <= ST_IDLE;
            op_reg <= OP_NONE;
            {form_reg, mem_reg, ctx_ph_reg, half_reg} <= 4'h0;
            {dst_reg, idx_reg, len_reg} <= 10'h000;
            {cnt_reg, last_reg} <= 4'h0;
            rd_addr_reg <= 20'h00000;
            buf_reg <= 24'h000000;
            {sel_reg, corr_reg} <= 16'h0000;
            off_reg <= 16'h0000;
        end else begin
            st_reg <= st_next;
            if (go) begin
                op_reg <= w_op;
                form_reg <= w_form;
                mem_reg <= w_mem;
                dst_reg <= w_dst;
                len_reg <= I_PWDATA[CMD_LEN_LSB +: 4];
                cnt_reg <= RD_B;
                last_reg <= go_last;
                ctx_ph_reg <= 1'b0;
                rd_addr_reg <= go_addr;
                buf_reg <= {4'h0, opa_reg};
            end else if ((st_reg == ST_READ) && mem_take) begin
                buf_reg[{cnt_reg, 3'h0} +: 8] <= I_MEM_RDATA;
                rd_addr_reg <= rd_addr_reg + 20'h00001;
                cnt_reg <= rd_done ? RD_B : cnt_reg + 2'h1;
                if (rd_done && (op_reg == OP_CTX) && !ctx_ph_reg) begin
                    ctx_ph_reg <= 1'b1;
                    last_reg <= RD_W;
                    rd_addr_reg <= opa_reg + {11'h0, I_MEM_RDATA, 1'b0};
                end
                if (rd_done && ctx_ph_reg) begin
                    sel_reg <= buf_reg[7:0];
                    corr_reg <= I_MEM_RDATA;
                    idx_reg <= 3'h0;
                    half_reg <= 1'b0;
                    off_reg <= 16'h0000;
                end
            end else if ((st_reg == ST_PUSH) && mem_take) begin
                cnt_reg <= push_done ? RD_B : cnt_reg + 2'h1;
            end else if (pop_step) begin
                idx_reg <= idx_reg + 3'h1;
                half_reg <= 1'b0;
                if (pop_sel) off_reg <= off_reg + POP_STEP;
            end else if ((st_reg == ST_POP) && mem_take) begin
                half_reg <= 1'b1;
            end
        end
    end

    // Architectural registers
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            {pc_reg, opa_reg, interrupt_table_base_reg} <= 60'h0;
            {opb_reg, usp_reg, isp_reg, flg_reg} <= 64'h0;
            for (int i = 0; i < 8; i++) gpr_reg[i] <= 16'h0000;
            err_reg <= 1'b0;
            iblk_reg <= 1'b0;
        end else begin
            if (apb_wr) begin
                if (I_PADDR == OFS_PC) pc_reg <= I_PWDATA[19:0];
                if (I_PADDR == OFS_OPA) opa_reg <= I_PWDATA[19:0];
                if (I_PADDR == OFS_OPB) opb_reg <= I_PWDATA[15:0];
                if (I_PADDR == OFS_USP) usp_reg <= I_PWDATA[15:0];
                if (I_PADDR == OFS_ISP) isp_reg <= I_PWDATA[15:0];
                if (I_PADDR == OFS_FLG) flg_reg <= I_PWDATA[15:0];
                if (I_PADDR == OFS_INTERRUPT_TABLE_BASE) interrupt_table_base_reg <= I_PWDATA[19:0];
                if (hit_gpr) gpr_reg[I_PADDR[4:2]] <= I_PWDATA[15:0];
            end
            if (go_err) err_reg <= 1'b1;
            else if (go) err_reg <= 1'b0;
            // Block holds until the next instruction is issued
            if (go) iblk_reg <= 1'b0;
            if (push_done) pc_reg <= call_tgt;
            if (sp_we && sp_sel_u) usp_reg <= sp_wv;
            if (sp_we && !sp_sel_u) isp_reg <= sp_wv;
            if ((st_reg == ST_POP) && mem_take) begin
                if (half_reg) gpr_reg[idx_reg][15:8] <= I_MEM_RDATA;
                else gpr_reg[idx_reg][7:0] <= I_MEM_RDATA;
            end
            if (exec_cl) begin
                iblk_reg <= 1'b1;
                unique case (scl_dst_e'(dst_reg))
                    DST_FB: gpr_reg[GPR_FB] <= buf_reg[15:0];
                    DST_SB: gpr_reg[GPR_SB] <= buf_reg[15:0];
                    DST_ISP: isp_reg <= buf_reg[15:0];
                    DST_FLG: flg_reg <= buf_reg[15:0];
                    DST_ITBH: interrupt_table_base_reg[19:16] <= buf_reg[3:0];
                    DST_ITBL: interrupt_table_base_reg[15:0] <= buf_reg[15:0];
                    default: ;
                endcase
            end
            if (exec_el) begin
                gpr_reg[dst_reg] <= el_val;
                flg_reg[FLG_S_BIT] <= el_msb;
                flg_reg[FLG_Z_BIT] <= el_zero;
            end
            // Two halves in successive cycles, as two control loads would
            if ((st_reg == ST_EXEC) && (op_reg == OP_ITBL)) interrupt_table_base_reg[19:16] <= buf_reg[19:16];
            if (st_reg == ST_ITBL) begin
                interrupt_table_base_reg[15:0] <= buf_reg[15:0];
                iblk_reg <= 1'b1;
            end
        end
    end

    // Read mux
    always_comb begin
        O_PRDATA = 32'h0;
        if (hit_gpr) O_PRDATA = {16'h0, gpr_reg[I_PADDR[4:2]]};
        case (I_PADDR)
            OFS_CMD: O_PRDATA = {20'h0, len_reg, dst_reg, mem_reg, form_reg, op_reg};
            OFS_PC: O_PRDATA = {12'h0, pc_reg};
            OFS_OPA: O_PRDATA = {12'h0, opa_reg};
            OFS_OPB: O_PRDATA = {16'h0, opb_reg};
            OFS_STAT: O_PRDATA = {29'h0, iblk_reg, err_reg, !idle};
            OFS_USP: O_PRDATA = {16'h0, usp_reg};
            OFS_ISP: O_PRDATA = {16'h0, isp_reg};
            OFS_FLG: O_PRDATA = {16'h0, flg_reg};
            OFS_INTERRUPT_TABLE_BASE: O_PRDATA = {12'h0, interrupt_table_base_reg};
            default: ;
        endcase
    end

    // Zero wait states; writes during a run are refused to keep state coherent
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = apb_acc & (!mapped | (I_PWRITE & !idle));
    assign O_BUSY = !idle;
    assign O_IRQ_BLOCK = iblk_reg;
    assign O_PC = pc_reg;

    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_SRST);

    AST_PUSH_HIGH: assert property (
        (st_reg == ST_PUSH) && (cnt_reg == RD_B) |-> O_MEM.we
            && (O_MEM.addr == stk_addr(sp_cur - PUSH_OFS_H))
            && (O_MEM.wdata == {4'h0, ret_addr[19:16]}))
        else $error("high return byte not at SP-1");
    AST_CALL_SP: assert property (
        push_done |=> sp_cur == $past(sp_cur) - PUSH_OFS_L)
        else $error("call did not drop SP by 3");
    AST_DCALL_PC: assert property (
        push_done && (op_reg == OP_DCALL) && !form_reg
            |=> pc_reg == $past(pc_reg) + $past(opa_reg))
        else $error("relative call target wrong");
    AST_SCALL_PC: assert property (
        push_done && (op_reg == OP_SCALL) |=> pc_reg[19:16] == PCH_SPECIAL)
        else $error("special call upper bits wrong");
    AST_VEC_RANGE: assert property (
        (st_reg == ST_READ) && (op_reg == OP_SCALL)
            |-> (O_MEM.addr >= VEC_LO) && (O_MEM.addr <= VEC_TOP + 20'h1))
        else $error("vector read outside table");
    AST_IND_LOW: assert property (
        (st_reg == ST_READ) && (op_reg == OP_ICALL) && (cnt_reg == RD_B) |-> O_MEM.addr == opa_reg)
        else $error("indirect operand not read from its low byte");
    AST_CL_FLG: assert property (
        exec_cl && (dst_reg != DST_FLG) |=> $stable(flg_reg))
        else $error("control load changed flags");
    AST_IBLK: assert property (
        exec_cl |=> O_IRQ_BLOCK throughout (!go [*1]))
        else $error("interrupt block missing after control load");
    AST_EL_Z: assert property (
        exec_el && form_reg |=> flg_reg[FLG_Z_BIT] == (gpr_reg[dst_reg] == 16'h0))
        else $error("zero flag wrong after extended load");
    AST_ITBL: assert property (
        (st_reg == ST_EXEC) && (op_reg == OP_ITBL) |-> ##2 interrupt_table_base_reg == $past(buf_reg[19:0], 2))
        else $error("table base not loaded");

endmodule : scl_exec

// >>> dv/scl_mem_model.sv
`timescale 1ns/1ps
module scl_mem_model
    import scl_pkg::*;
(
    // Clock and pace
    input wire logic i_clk,
    input wire logic i_slow,
    // Byte port from the block
    input wire scl_mem_s i_mem,
    output logic o_ready,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:1048575];
    logic [7:0] tick_reg = 8'h00;
    // Slow mode answers one cycle in four
    assign o_ready = !i_slow || (tick_reg[1:0] == 2'h3);
    // Noise outside an answer, so a late sample never sees a stale byte
    always_comb begin
        if (o_ready && i_mem.valid && !i_mem.we) begin
            o_rdata = mem[i_mem.addr];
        end else begin
            o_rdata = ~tick_reg;
        end
    end
    always @(posedge i_clk) begin
        tick_reg <= tick_reg + 8'h01;
        if (o_ready && i_mem.valid && i_mem.we) begin
            mem[i_mem.addr] <= i_mem.wdata;
        end
    end
endmodule : scl_mem_model

// >>> dv/test_subroutine_call_and_ctrl_load.sv
`timescale 1ns/1ps
module test_subroutine_call_and_ctrl_load;
    import scl_pkg::*;
    logic clk, srst, psel, penable, pwrite, slow, pready, pslverr, busy, iblk, mready, e;
    logic [7:0] paddr, mrdata;
    logic [31:0] pwdata, prdata, q;
    logic [19:0] pc;
    scl_mem_s mem_bus;
    int bad_count = 0;
    int comparisons = 0;
    scl_exec i_dut(.I_SYS_CLK(clk), .I_SRST(srst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .O_MEM(mem_bus), .I_MEM_READY(mready),
        .I_MEM_RDATA(mrdata), .O_BUSY(busy), .O_IRQ_BLOCK(iblk), .O_PC(pc));
    scl_mem_model u_mem(.i_clk(clk), .i_slow(slow), .i_mem(mem_bus), .o_ready(mready),
        .o_rdata(mrdata));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task conclude;
        if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (n >= 20) begin
            chk(32'(n), 32'h0);
            conclude();
        end
    endtask : apb
    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd
    task poke(input logic [19:0] a, input logic [7:0] d);
        u_mem.mem[a] = d;
    endtask : poke
    // Issues one instruction; waiting is left to the caller
    task run(input logic [2:0] op, input logic f, input logic m, input logic [2:0] dst,
        input logic [3:0] len, input logic [19:0] pcv, input logic [19:0] opa,
        input logic [15:0] opb);
        apb(1'b1, OFS_PC, {12'h0, pcv});
        apb(1'b1, OFS_OPA, {12'h0, opa});
        apb(1'b1, OFS_OPB, {16'h0, opb});
        apb(1'b1, OFS_CMD, {20'h0, len, dst, m, f, op});
    endtask : run
    task wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n >= 400) begin
            chk(32'(n), 32'h0);
            conclude();
        end
    endtask : wait_idle
    task calls;
        apb(1'b1, OFS_FLG, 32'h80);
        apb(1'b1, OFS_USP, 32'h400);
        run(OP_DCALL, 1'b0, 1'b0, 3'h0, 4'h3, 20'h10000, 20'h08000, 16'h0);
        wait_idle();
        chk({12'h0, pc}, 32'h18000);
        chk({24'h0, u_mem.mem[20'h003ff]}, 32'h01);
        chk({24'h0, u_mem.mem[20'h003fe]}, 32'h00);
        chk({24'h0, u_mem.mem[20'h003fd]}, 32'h03);
        rd(OFS_USP, 32'h3fd);
        run(OP_DCALL, 1'b0, 1'b0, 3'h0, 4'h3, 20'h18000, 20'hf8000, 16'h0);
        wait_idle();
        rd(OFS_STAT, 32'h2);
        run(OP_DCALL, 1'b1, 1'b0, 3'h0, 4'h4, 20'h18000, 20'habcde, 16'h0);
        wait_idle();
        chk({12'h0, pc}, 32'habcde);
        rd(OFS_USP, 32'h3fa);
    endtask : calls
    task indirect;
        poke(20'h00200, 8'h34);
        poke(20'h00201, 8'h12);
        poke(20'h00202, 8'h0e);
        poke(20'h00210, 8'hfe);
        poke(20'h00211, 8'hff);
        slow = 1'b1;
        run(OP_ICALL, 1'b1, 1'b1, 3'h0, 4'h2, 20'h30000, 20'h00200, 16'h0);
        apb(1'b1, OFS_PC, 32'h0);
        chk({31'h0, e}, 32'h1);
        wait_idle();
        chk({12'h0, pc}, 32'he1234);
        run(OP_ICALL, 1'b0, 1'b1, 3'h0, 4'h2, 20'h20000, 20'h00210, 16'h0);
        wait_idle();
        chk({12'h0, pc}, 32'h1fffe);
        slow = 1'b0;
        run(OP_ICALL, 1'b0, 1'b0, 3'h0, 4'h2, 20'h20000, 20'h0fffe, 16'h0);
        wait_idle();
        chk({12'h0, pc}, 32'h1fffe);
    endtask : indirect
    task special;
        poke(20'hffe00, 8'h78);
        poke(20'hffe01, 8'h56);
        poke(20'hfffda, 8'hcd);
        poke(20'hfffdb, 8'hab);
        apb(1'b1, OFS_USP, 32'h500);
        run(OP_SCALL, 1'b0, 1'b0, 3'h0, 4'h2, 20'h12345, 20'h000ff, 16'h0);
        wait_idle();
        chk({12'h0, pc}, 32'hf5678);
        chk({24'h0, u_mem.mem[20'h004fd]}, 32'h47);
        chk({24'h0, u_mem.mem[20'h004ff]}, 32'h01);
        run(OP_SCALL, 1'b0, 1'b0, 3'h0, 4'h2, 20'h12345, 20'h00012, 16'h0);
        wait_idle();
        chk({12'h0, pc}, 32'hfabcd);
        run(OP_SCALL, 1'b0, 1'b0, 3'h0, 4'h2, 20'h12345, 20'h00011, 16'h0);
        wait_idle();
        rd(OFS_STAT, 32'h2);
    endtask : special
    task ctrl_load;
        logic [7:0] a [4];
        a = '{8'h5c, 8'h58, OFS_USP, OFS_ISP};
        for (int i = 0; i < 4; i++) begin
            run(OP_CLOAD, 1'b0, 1'b0, 3'(i), 4'h2, 20'h1000, 20'(16'h1a2b + i), 16'h0);
            wait_idle();
            rd(a[i], 32'(16'h1a2b + i));
            rd(OFS_FLG, 32'h80);
            chk({31'h0, iblk}, 32'h1);
        end
        run(OP_CLOAD, 1'b0, 1'b0, DST_FLG, 4'h2, 20'h1000, 20'h0000c, 16'h0);
        wait_idle();
        rd(OFS_FLG, 32'h0c);
        run(OP_CLOAD, 1'b0, 1'b0, DST_SP, 4'h2, 20'h1000, 20'h00777, 16'h0);
        wait_idle();
        rd(OFS_ISP, 32'h777);
        poke(20'h00700, 8'h11);
        poke(20'h00701, 8'h22);
        run(OP_CLOAD, 1'b0, 1'b1, DST_FB, 4'h2, 20'h1000, 20'h00700, 16'h0);
        wait_idle();
        rd(8'h5c, 32'h2211);
        run(OP_CLOAD, 1'b0, 1'b0, DST_ITBH, 4'h2, 20'h1000, 20'h00005, 16'h0);
        wait_idle();
        run(OP_CLOAD, 1'b0, 1'b0, DST_ITBL, 4'h2, 20'h1000, 20'h01234, 16'h0);
        wait_idle();
        rd(OFS_INTERRUPT_TABLE_BASE, 32'h51234);
        run(OP_DCALL, 1'b1, 1'b0, 3'h0, 4'h4, 20'h1000, 20'h02000, 16'h0);
        wait_idle();
        chk({31'h0, iblk}, 32'h0);
        run(OP_ITBL, 1'b0, 1'b0, 3'h0, 4'h4, 20'h1000, 20'hf0000, 16'h0);
        wait_idle();
        rd(OFS_INTERRUPT_TABLE_BASE, 32'hf0000);
        chk({31'h0, iblk}, 32'h1);
    endtask : ctrl_load
    task ctx_ext;
        apb(1'b1, OFS_FLG, 32'h80);
        apb(1'b1, OFS_USP, 32'h600);
        apb(1'b1, 8'h40, 32'h7777);
        poke(20'h00300, 8'h02);
        poke(20'h40004, 8'h90);
        poke(20'h40005, 8'h04);
        poke(20'h00600, 8'h11);
        poke(20'h00601, 8'ha0);
        poke(20'h00602, 8'h22);
        poke(20'h00603, 8'hf0);
        run(OP_CTX, 1'b0, 1'b0, 3'h0, 4'h7, 20'h1000, 20'h40000, 16'h0300);
        wait_idle();
        rd(8'h50, 32'ha011);
        rd(8'h5c, 32'hf022);
        rd(8'h40, 32'h7777);
        rd(OFS_USP, 32'h604);
        poke(20'h8f000, 8'h80);
        run(OP_ELOAD, 1'b0, 1'b0, GPR_A0, 4'h4, 20'h1000, 20'h8f000, 16'h0);
        wait_idle();
        rd(8'h50, 32'h0080);
        rd(OFS_FLG, 32'h80);
        poke(20'h8f010, 8'h01);
        poke(20'h8f011, 8'h80);
        run(OP_ELOAD, 1'b1, 1'b0, 3'h1, 4'h4, 20'h1000, 20'h8f010, 16'h0);
        wait_idle();
        rd(8'h44, 32'h8001);
        rd(OFS_FLG, 32'h88);
        run(OP_ELOAD, 1'b1, 1'b0, 3'h1, 4'h4, 20'h1000, 20'h8f012, 16'h0);
        wait_idle();
        rd(OFS_FLG, 32'h84);
        // Byte load into a data register keeps its high byte
        apb(1'b1, 8'h48, 32'h1234);
        run(OP_ELOAD, 1'b0, 1'b0, 3'h2, 4'h4, 20'h1000, 20'h8f000, 16'h0);
        wait_idle();
        rd(8'h48, 32'h1280);
        rd(OFS_FLG, 32'h88);
    endtask : ctx_ext
    initial begin
        {srst, psel, penable, pwrite, slow} = 5'b10000;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        poke(20'h8f012, 8'h00);
        poke(20'h8f013, 8'h00);
        apb(1'b0, 8'h30, 32'h0);
        chk({e, q[30:0]}, 32'h80000000);
        calls();
        indirect();
        special();
        ctrl_load();
        ctx_ext();
        conclude();
    end
endmodule : test_subroutine_call_and_ctrl_load
